/* logic/tpr_params.svh */
// constants for the tag page read/write command block
`ifndef TPR_PARAMS_SVH
`define TPR_PARAMS_SVH
`define TPR_OP_MULTI_READ 8'h3a
`define TPR_OP_PAGE_WRITE 8'ha2
`define TPR_OP_CNT_READ 8'h39
`define TPR_CNT_ARG 8'h02
`define TPR_LEN_MULTI_READ 3'd3
`define TPR_LEN_PAGE_WRITE 3'd6
`define TPR_LEN_CNT_READ 3'd2
`define TPR_LAST_PAGE 8'h3b
`define TPR_FIRST_WR_PAGE 8'h02
`define TPR_PWD_PAGE 8'h3a
`define TPR_PASSWORD_ACK_VALUE_PAGE 8'h3b
`define TPR_TEAR_PAGE_LOCK 8'h02
`define TPR_TEAR_PAGE_CC 8'h03
`define TPR_TEAR_PAGE_DYN 8'h28
`define TPR_ACK 4'ha
`define TPR_NAK 4'h0
`define TPR_ACK_N 9
`define TPR_CLK_NS 4
`define TPR_FDT_MIN_NS (((`TPR_ACK_N * 128 + 84) * 1000000 + 13559) / 13560)
`define TPR_FDT_MIN_CYC ((`TPR_FDT_MIN_NS + `TPR_CLK_NS - 1) / `TPR_CLK_NS)
`define TPR_TO_READ_NS 5000000
`define TPR_TO_WRITE_NS 10000000
`define TPR_TO_READ_CYC (`TPR_TO_READ_NS / `TPR_CLK_NS)
`define TPR_TO_WRITE_CYC (`TPR_TO_WRITE_NS / `TPR_CLK_NS)
`define TPR_FIFO_DEPTH 8
`endif

/* logic/tpr_pkg.sv */
// types shared by both ends of the tag command link
package tpr_pkg;
  typedef enum logic [2:0] {
    TPR_D_IDLE = 3'b001,
    TPR_D_GAP = 3'b010,
    TPR_D_RESP = 3'b100
  } tpr_dev_state_t;
  typedef enum logic [3:0] {
    TPR_H_IDLE = 4'b0001,
    TPR_H_SEND = 4'b0010,
    TPR_H_WAIT = 4'b0100,
    TPR_H_DONE = 4'b1000
  } tpr_host_state_t;
  typedef enum logic [1:0] {
    TPR_M_CODE = 2'h0,
    TPR_M_READ = 2'h1,
    TPR_M_CNT = 2'h2
  } tpr_mode_t;
  // response word: last, code flag, byte (code in low nibble)
  typedef struct packed {
    logic last;
    logic is_code;
    logic [7:0] data;
  } tpr_word_t;
endpackage

/* logic/tpr_link_if.sv */
// byte link between reader end and tag end
`timescale 1ns/100ps
`default_nettype none
interface tpr_link_if;
  logic rdr_valid;
  logic [7:0] rdr_data;
  logic rdr_last;
  logic rdr_crc_ok;
  logic tag_valid;
  logic [7:0] tag_data;
  logic tag_code;
  logic tag_last;
  logic tag_ready;
  modport tag (input rdr_valid, rdr_data, rdr_last, rdr_crc_ok, tag_ready,
               output tag_valid, tag_data, tag_code, tag_last);
  modport reader (output rdr_valid, rdr_data, rdr_last, rdr_crc_ok, tag_ready,
                  input tag_valid, tag_data, tag_code, tag_last);
endinterface
`default_nettype wire

/* logic/tpr_fifo.sv */
// parameterised valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module tpr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_ff[wr_ff] <= in_data_i;
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* logic/tpr_tag.sv */
// tag end: multi-page read, page write and counter read commands
// Overview of operation
// - multi read: 3Ah, first, last, CRC
// - reply all pages first..last, four bytes each
// - out-of-range first or last page gives NAK
// - first page 00h..3Bh accepted, above NAK
// - last below first gives NAK
// - unauthenticated read-protected range at/above start: NAK
// - authenticated: read ignores password protection
// - password and ack pages read as 00h
// - reader takes the reply word by word, no chaining; the reader holds one word and stalls the tag via tag_ready
// - reply no earlier than n=9; timeouts 5/10 ms
// - write: A2h, page, four bytes; ACK/NAK
// - write pages 02h..3Bh accepted, above NAK
// - write-locked pages are never reprogrammed
// - unauthenticated write at/above start page: NAK
// - authenticated: write ignores password protection
// - pages 02h, 03h, 28h written tearing-safe
// - counter read: 39h, 02h; three-byte value reply
// - start page is lowest protected page
// - level bit: write-only or read-and-write protection
`include "tpr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tpr_tag
  import tpr_pkg::*;
#(
  parameter logic [31:0] FDT_MIN_CYC = 32'(`TPR_FDT_MIN_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tpr_link_if.tag link,
  input wire logic authenticated_i,
  input wire logic [7:0] protection_start_page_i,
  input wire logic protection_level_bit_i,
  input wire logic [63:0] page_lock_i,
  input wire logic [23:0] counter_value_i,
  output logic busy_o,
  output logic wr_done_o
);
  typedef struct packed {
    tpr_dev_state_t st;
    logic [2:0] cnt;
    logic ovf;
    logic [6:0][7:0] buf_b;
    logic [31:0] gap;
    tpr_mode_t mode;
    logic [3:0] code;
    logic [7:0] ptr;
    logic [7:0] endp;
    logic [1:0] bidx;
    logic tear;
    logic [7:0] tear_page;
    logic [31:0] tear_data;
    logic busy;
    logic wr_done;
  } tpr_tag_st_t;

  tpr_tag_st_t st_ff;
  tpr_tag_st_t nxt_st;
  logic [31:0] mem_ff [64];
  logic mem_we;
  logic [7:0] mem_addr;
  logic [31:0] mem_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  tpr_word_t fifo_in;
  logic [9:0] fifo_out;
  logic [7:0] page_rd;
  logic [31:0] page_word;

  function automatic logic is_tear_page(input logic [7:0] pg);
    is_tear_page = (pg == `TPR_TEAR_PAGE_LOCK) || (pg == `TPR_TEAR_PAGE_CC) ||
                   (pg == `TPR_TEAR_PAGE_DYN);
  endfunction

  function automatic logic is_secret_page(input logic [7:0] pg);
    is_secret_page = (pg == `TPR_PWD_PAGE) || (pg == `TPR_PASSWORD_ACK_VALUE_PAGE);
  endfunction

  // page under the read pointer, secrets replaced by zero
  assign page_rd = st_ff.ptr;
  assign page_word = is_secret_page(page_rd) ? 32'h0000_0000 : mem_ff[page_rd[5:0]];

  always_comb
  begin
    logic [2:0] len;
    logic [7:0] op;
    logic [7:0] a0;
    logic [7:0] a1;
    logic rd_protection_level_bit;
    len = 3'd0;
    op = 8'h00;
    a0 = 8'h00;
    a1 = 8'h00;
    rd_protection_level_bit = 1'b0;
    nxt_st = st_ff;
    nxt_st.wr_done = 1'b0;
    mem_we = 1'b0;
    mem_addr = 8'h00;
    mem_data = 32'h0000_0000;
    fifo_in_valid = 1'b0;
    fifo_in = '0;
    case (st_ff.st)
      TPR_D_IDLE:
      begin
        if (link.rdr_valid)
        begin
          if (st_ff.cnt == 3'd7)
            nxt_st.ovf = 1'b1;
          else
          begin
            nxt_st.buf_b[st_ff.cnt] = link.rdr_data;
            nxt_st.cnt = st_ff.cnt + 3'd1;
          end
          if (link.rdr_last)
          begin
            len = (st_ff.cnt == 3'd7) ? 3'd0 : st_ff.cnt + 3'd1;
            op = nxt_st.buf_b[0];
            a0 = nxt_st.buf_b[1];
            a1 = nxt_st.buf_b[2];
            nxt_st.cnt = 3'd0;
            nxt_st.ovf = 1'b0;
            nxt_st.gap = 32'd0;
            nxt_st.busy = 1'b1;
            nxt_st.st = TPR_D_GAP;
            nxt_st.mode = TPR_M_CODE;
            nxt_st.code = `TPR_NAK;
            nxt_st.bidx = 2'd0;
            // protection covers pages at or above the start page
            rd_protection_level_bit = !authenticated_i && protection_level_bit_i &&
                      (a1 >= protection_start_page_i);
            if (!link.rdr_crc_ok || st_ff.ovf)
              nxt_st.code = `TPR_NAK;
            else if (op == `TPR_OP_MULTI_READ && len == `TPR_LEN_MULTI_READ)
            begin
              if (a0 <= `TPR_LAST_PAGE && a1 <= `TPR_LAST_PAGE && a1 >= a0 && !rd_protection_level_bit)
              begin
                nxt_st.mode = TPR_M_READ;
                nxt_st.ptr = a0;
                nxt_st.endp = a1;
              end
            end
            else if (op == `TPR_OP_PAGE_WRITE && len == `TPR_LEN_PAGE_WRITE)
            begin
              if (a0 >= `TPR_FIRST_WR_PAGE && a0 <= `TPR_LAST_PAGE &&
                  !page_lock_i[a0[5:0]] &&
                  (authenticated_i || a0 < protection_start_page_i))
              begin
                nxt_st.code = `TPR_ACK;
                nxt_st.wr_done = 1'b1;
                if (is_tear_page(a0))
                begin
                  // staged word lands whole in one commit cycle
                  nxt_st.tear = 1'b1;
                  nxt_st.tear_page = a0;
                  nxt_st.tear_data = {nxt_st.buf_b[5], nxt_st.buf_b[4], nxt_st.buf_b[3], nxt_st.buf_b[2]};
                end
                else
                begin
                  mem_we = 1'b1;
                  mem_addr = a0;
                  mem_data = {nxt_st.buf_b[5], nxt_st.buf_b[4], nxt_st.buf_b[3], nxt_st.buf_b[2]};
                end
              end
            end
            else if (op == `TPR_OP_CNT_READ && len == `TPR_LEN_CNT_READ)
            begin
              if (a0 == `TPR_CNT_ARG)
                nxt_st.mode = TPR_M_CNT;
            end
          end
        end
      end
      TPR_D_GAP:
      begin
        if (st_ff.tear)
        begin
          mem_we = 1'b1;
          mem_addr = st_ff.tear_page;
          mem_data = st_ff.tear_data;
          nxt_st.tear = 1'b0;
        end
        nxt_st.gap = st_ff.gap + 32'd1;
        if (st_ff.gap + 32'd1 >= FDT_MIN_CYC)
          nxt_st.st = TPR_D_RESP;
      end
      TPR_D_RESP:
      begin
        fifo_in_valid = 1'b1;
        case (st_ff.mode)
          TPR_M_READ:
          begin
            fifo_in.data = page_word[8*st_ff.bidx +: 8];
            fifo_in.last = (st_ff.ptr == st_ff.endp) && (st_ff.bidx == 2'd3);
          end
          TPR_M_CNT:
          begin
            fifo_in.data = counter_value_i[8*st_ff.bidx +: 8];
            fifo_in.last = (st_ff.bidx == 2'd2);
          end
          default:
          begin
            fifo_in.is_code = 1'b1;
            fifo_in.data = {4'h0, st_ff.code};
            fifo_in.last = 1'b1;
          end
        endcase
        if (fifo_in_ready)
        begin
          nxt_st.bidx = st_ff.bidx + 2'd1;
          if (st_ff.bidx == 2'd3)
            nxt_st.ptr = st_ff.ptr + 8'd1;
          if (fifo_in.last)
          begin
            nxt_st.st = TPR_D_IDLE;
            nxt_st.busy = 1'b0;
          end
        end
      end
      default:
      begin
        nxt_st.st = TPR_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
      st_ff.st <= TPR_D_IDLE;
      st_ff.mode <= TPR_M_CODE;
    end
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 64; i++)
        mem_ff[i] <= 32'h0000_0000;
    end
    else if (mem_we && !page_lock_i[mem_addr[5:0]])
      mem_ff[mem_addr[5:0]] <= mem_data;
  end

  tpr_fifo #(
    .WIDTH(10),
    .DEPTH(`TPR_FIFO_DEPTH)
  ) u_rsp_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(link.tag_valid),
    .out_ready_i(link.tag_ready),
    .out_data_o(fifo_out)
  );

  assign link.tag_last = fifo_out[9];
  assign link.tag_code = fifo_out[8];
  assign link.tag_data = fifo_out[7:0];
  assign busy_o = st_ff.busy;
  assign wr_done_o = st_ff.wr_done;
endmodule
`default_nettype wire

/* logic/tpr_reader.sv */
// reader end: sends command frames and collects replies
`include "tpr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tpr_reader
  import tpr_pkg::*;
#(
  parameter logic [31:0] TO_READ_CYC = 32'(`TPR_TO_READ_CYC),
  parameter logic [31:0] TO_WRITE_CYC = 32'(`TPR_TO_WRITE_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tpr_link_if.reader link,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [7:0] cmd_arg0_i,
  input wire logic [7:0] cmd_arg1_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic cmd_crc_bad_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_code_o,
  output logic rsp_last_o,
  input wire logic rsp_ready_i,
  output logic timeout_o
);
  typedef struct packed {
    tpr_host_state_t st;
    logic [6:0][7:0] buf_b;
    logic [2:0] len;
    logic [2:0] idx;
    logic crc_bad;
    logic [31:0] to_lim;
    logic [31:0] to_cnt;
    logic got;
    logic rdr_valid;
    logic [7:0] rdr_data;
    logic rdr_last;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_code;
    logic rsp_last;
    logic timeout;
  } tpr_rdr_st_t;

  tpr_rdr_st_t st_ff;
  tpr_rdr_st_t nxt_st;
  logic take;

  function automatic logic [2:0] frame_len(input logic [7:0] op);
    case (op)
      `TPR_OP_MULTI_READ: frame_len = `TPR_LEN_MULTI_READ;
      `TPR_OP_PAGE_WRITE: frame_len = `TPR_LEN_PAGE_WRITE;
      `TPR_OP_CNT_READ: frame_len = `TPR_LEN_CNT_READ;
      default: frame_len = 3'd1;
    endcase
  endfunction

  // one word is taken at a time while the holding register is empty or draining to the user
  assign take = (st_ff.st == TPR_H_WAIT) && (!st_ff.rsp_valid || rsp_ready_i);
  assign link.tag_ready = take;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.timeout = 1'b0;
    nxt_st.rdr_valid = 1'b0;
    nxt_st.rdr_last = 1'b0;
    if (st_ff.rsp_valid && rsp_ready_i)
      nxt_st.rsp_valid = 1'b0;
    case (st_ff.st)
      TPR_H_IDLE:
      begin
        if (cmd_valid_i)
        begin
          nxt_st.buf_b = {cmd_data_i, cmd_arg1_i, cmd_arg0_i, cmd_op_i};
          if (cmd_op_i == `TPR_OP_PAGE_WRITE)
            nxt_st.buf_b = {8'h00, cmd_data_i, cmd_arg0_i, cmd_op_i};
          nxt_st.len = frame_len(cmd_op_i);
          nxt_st.idx = 3'd0;
          nxt_st.crc_bad = cmd_crc_bad_i;
          nxt_st.to_lim = (cmd_op_i == `TPR_OP_PAGE_WRITE) ? TO_WRITE_CYC : TO_READ_CYC;
          nxt_st.st = TPR_H_SEND;
        end
      end
      TPR_H_SEND:
      begin
        nxt_st.rdr_valid = 1'b1;
        nxt_st.rdr_data = st_ff.buf_b[st_ff.idx];
        nxt_st.rdr_last = (st_ff.idx + 3'd1 == st_ff.len);
        nxt_st.idx = st_ff.idx + 3'd1;
        if (st_ff.idx + 3'd1 == st_ff.len)
        begin
          nxt_st.to_cnt = 32'd0;
          nxt_st.got = 1'b0;
          nxt_st.st = TPR_H_WAIT;
        end
      end
      TPR_H_WAIT:
      begin
        if (!st_ff.got)
          nxt_st.to_cnt = st_ff.to_cnt + 32'd1;
        if (take && link.tag_valid)
        begin
          nxt_st.got = 1'b1;
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data = link.tag_data;
          nxt_st.rsp_code = link.tag_code;
          nxt_st.rsp_last = link.tag_last;
          if (link.tag_last)
            nxt_st.st = TPR_H_DONE;
        end
        else if (!st_ff.got && st_ff.to_cnt + 32'd1 >= st_ff.to_lim)
        begin
          nxt_st.timeout = 1'b1;
          nxt_st.st = TPR_H_DONE;
        end
      end
      TPR_H_DONE:
      begin
        nxt_st.st = TPR_H_IDLE;
      end
      default:
      begin
        nxt_st.st = TPR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
      st_ff.st <= TPR_H_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign link.rdr_valid = st_ff.rdr_valid;
  assign link.rdr_data = st_ff.rdr_data;
  assign link.rdr_last = st_ff.rdr_last;
  assign link.rdr_crc_ok = !st_ff.crc_bad;
  assign cmd_ready_o = (st_ff.st == TPR_H_IDLE);
  assign rsp_valid_o = st_ff.rsp_valid;
  assign rsp_data_o = st_ff.rsp_data;
  assign rsp_code_o = st_ff.rsp_code;
  assign rsp_last_o = st_ff.rsp_last;
  assign timeout_o = st_ff.timeout;
endmodule
`default_nettype wire

/* sim/tpr_link_chk.sv */
// assertions on the byte link between reader and tag ends
`include "tpr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tpr_link_chk #(
  parameter logic [31:0] FDT_MIN_CYC = 32'(`TPR_FDT_MIN_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rdr_valid,
  input wire logic [7:0] rdr_data,
  input wire logic rdr_last,
  input wire logic rdr_crc_ok,
  input wire logic tag_valid,
  input wire logic [7:0] tag_data,
  input wire logic tag_code,
  input wire logic tag_last,
  input wire logic tag_ready
);
  logic in_ff, first_ff, bad_ff, sof, fend, take;
  logic [31:0] gap_ff;
  logic [9:0] wcnt_ff;
  logic [7:0] op_ff, a0_ff, a1_ff;
  logic [1:0] idx_ff;
  assign sof = rdr_valid && !in_ff;
  assign fend = rdr_valid && rdr_last;
  assign take = tag_valid && tag_ready;
  // frame tracking and reply word counting
  always_ff @(posedge clk_i)
  begin
    in_ff <= rst_i ? 1'b0 : (rdr_valid ? !rdr_last : in_ff);
    first_ff <= rst_i ? 1'b0 : (fend ? 1'b1 : (take ? 1'b0 : first_ff));
    gap_ff <= fend ? 32'd1 : ((gap_ff == '1) ? gap_ff : gap_ff + 32'd1);
    bad_ff <= fend ? !rdr_crc_ok : bad_ff;
    wcnt_ff <= fend ? 10'd0 : wcnt_ff + 10'(take);
    op_ff <= sof ? rdr_data : op_ff;
    idx_ff <= sof ? 2'd1 : idx_ff + 2'(rdr_valid && idx_ff != 2'd3);
    a0_ff <= (rdr_valid && idx_ff == 2'd1) ? rdr_data : a0_ff;
    a1_ff <= (rdr_valid && idx_ff == 2'd2) ? rdr_data : a1_ff;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reply_gap_min:
    assert property (tag_valid && first_ff |-> gap_ff >= FDT_MIN_CYC) else $error("reply before minimum delay");
  a_word_holds:
    assert property (tag_valid && !tag_ready |=> tag_valid && $stable(tag_data) && $stable(tag_last)
      && $stable(tag_code)) else $error("reply word changed while stalled");
  a_code_is_last:
    assert property (tag_valid && tag_code |-> tag_last && tag_data[7:4] == 4'h0) else $error("code word malformed");
  a_code_value:
    assert property (tag_valid && tag_code |-> tag_data[3:0] == `TPR_ACK || tag_data[3:0] == `TPR_NAK)
      else $error("code word not ack or nak");
  a_crc_nak:
    assert property (tag_valid && first_ff && bad_ff |-> tag_code && tag_data == {4'h0, `TPR_NAK})
      else $error("bad crc frame not refused");
  a_read_frame_len:
    assert property (sof && rdr_data == `TPR_OP_MULTI_READ |-> (rdr_valid && !rdr_last)[*2] ##1 fend)
      else $error("multi read frame length wrong");
  a_write_frame_len:
    assert property (sof && rdr_data == `TPR_OP_PAGE_WRITE |-> (rdr_valid && !rdr_last)[*5] ##1 fend)
      else $error("page write frame length wrong");
  a_cnt_frame_len:
    assert property (sof && rdr_data == `TPR_OP_CNT_READ |-> ##1 fend) else $error("counter frame length wrong");
  a_read_word_count:
    assert property (take && tag_last && !tag_code && op_ff == `TPR_OP_MULTI_READ
      |-> wcnt_ff == ({2'b0, a1_ff} - {2'b0, a0_ff}) * 10'd4 + 10'd3) else $error("read reply length wrong");
  a_cnt_word_count:
    assert property (take && tag_last && !tag_code && op_ff == `TPR_OP_CNT_READ |-> wcnt_ff == 10'd2)
      else $error("counter reply length wrong");
  c_read_reply: cover property (take && tag_last && !tag_code && op_ff == `TPR_OP_MULTI_READ);
  c_write_ack: cover property (take && tag_code && tag_data[3:0] == `TPR_ACK);
  c_nak: cover property (take && tag_code && tag_data[3:0] == `TPR_NAK);
  c_stall: cover property (tag_valid && !tag_ready);
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench joining the reader end to the tag end
`include "tpr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tpr_pkg::*;
  localparam logic [31:0] FDT = 32'd20;
  localparam logic [7:0] WPG [8] = '{8'h02, 8'h03, 8'h28, 8'h3b, 8'h3a, 8'h01, 8'h3c, 8'hff};
  localparam logic [7:0] OPS [4] = '{8'ha2, 8'ha2, 8'h3a, 8'h39};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid = 1'b0;
  logic [56:0] cmd_bus = '0;
  logic auth = 1'b0, lvl = 1'b0, rsp_ready = 1'b1;
  logic [7:0] start_pg = 8'hff;
  logic [63:0] lock = 64'h0;
  logic [23:0] cnt_val = 24'h0;
  logic cmd_ready, rsp_valid, rsp_code, rsp_last, timeout, busy, wr_done;
  logic [7:0] rsp_data;
  logic [31:0] seed = 32'h064b;
  logic [31:0] mem [64] = '{default: 32'h0};
  tpr_word_t exp_q [$];
  int n_fail = 0, samples_checked = 0, n_wr = 0, n_done = 0, n_to = 0;
  tpr_link_if link_bus ();
  tpr_reader #(.TO_READ_CYC(32'd200), .TO_WRITE_CYC(32'd400)) u_tpr_reader (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_bus), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_bus[7:0]), .cmd_arg0_i(cmd_bus[15:8]),
    .cmd_arg1_i(cmd_bus[23:16]), .cmd_data_i(cmd_bus[55:24]), .cmd_crc_bad_i(cmd_bus[56]),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_code_o(rsp_code),
    .rsp_last_o(rsp_last), .rsp_ready_i(rsp_ready), .timeout_o(timeout));
  tpr_tag #(.FDT_MIN_CYC(FDT)) u_tpr_tag (.clk_i(clk_i), .rst_i(rst_i), .link(link_bus), .authenticated_i(auth),
    .protection_start_page_i(start_pg), .protection_level_bit_i(lvl), .page_lock_i(lock),
    .counter_value_i(cnt_val), .busy_o(busy), .wr_done_o(wr_done));
  tpr_link_chk #(.FDT_MIN_CYC(FDT)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .rdr_valid(link_bus.rdr_valid),
    .rdr_data(link_bus.rdr_data), .rdr_last(link_bus.rdr_last), .rdr_crc_ok(link_bus.rdr_crc_ok),
    .tag_valid(link_bus.tag_valid), .tag_data(link_bus.tag_data), .tag_code(link_bus.tag_code),
    .tag_last(link_bus.tag_last), .tag_ready(link_bus.tag_ready));
  always #2 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic last, input logic code, input logic [7:0] d);
    exp_q.push_back({last, code, d});
  endtask
  // waits until the link is quiet and the reader is ready for a command
  task automatic idle();
    int k;
    k = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0 || cmd_ready !== 1'b1) && k < 4000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 4000)
      check("link idle", 10'h1, 10'h0);
    if (k >= 4000)
      end_of_test();
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] p0, input logic [7:0] p1, input logic [31:0] d,
                     input logic bad);
    logic ok;
    cmd_bus <= {bad, d, p1, p0, op};
    cmd_valid <= 1'b1;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    case (op)
      8'h3a:
      begin
        ok = !bad && p0 <= 8'h3b && p1 <= 8'h3b && p1 >= p0 && (auth || !lvl || p1 < start_pg);
        for (int p = p0; ok && p <= p1; p++)
          for (int b = 0; b < 4; b++)
            put(p == p1 && b == 3, 1'b0, (p >= 8'h3a) ? 8'h00 : mem[p][8*b +: 8]);
      end
      8'ha2:
      begin
        ok = !bad && p0 >= 8'h02 && p0 <= 8'h3b && !lock[p0[5:0]] && (auth || p0 < start_pg);
        if (ok)
          mem[p0[5:0]] = d;
        n_wr += int'(ok);
        put(1'b1, 1'b1, ok ? 8'h0a : 8'h00);
        ok = 1'b1;
      end
      8'h39:
      begin
        ok = !bad && p0 == 8'h02;
        for (int b = 0; ok && b < 3; b++)
          put(b == 2, 1'b0, cnt_val[8*b +: 8]);
      end
      default: ok = 1'b0;
    endcase
    if (!ok)
      put(1'b1, 1'b1, 8'h00);
    // settings may only change once the whole reply is in
    idle();
  endtask
  // stall source, event counters and reply comparison
  always @(posedge clk_i)
  begin
    seed <= lfsr(seed);
    rsp_ready <= seed[3] | seed[7];
    n_done += int'(!rst_i && wr_done === 1'b1);
    n_to += int'(!rst_i && timeout === 1'b1);
    if (!rst_i && rsp_valid === 1'b1 && rsp_ready)
    begin
      if (exp_q.size() == 0)
        check("spare word", {rsp_last, rsp_code, rsp_data}, 10'h3ff);
      else
        check("reply word", {rsp_last, rsp_code, rsp_data}, exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (WPG[i])
      cmd(8'ha2, WPG[i], 8'h00, seed ^ 32'(i), 1'b0);
    cmd(8'h3a, 8'h00, 8'h3b, 32'h0, 1'b0);
    cmd(8'h3a, 8'h3b, 8'h3c, 32'h0, 1'b0);
    cmd(8'h3a, 8'h3c, 8'h3c, 32'h0, 1'b0);
    cmd(8'h3a, 8'h05, 8'h04, 32'h0, 1'b0);
    $display("test ranges done");
    lock <= 64'h20;
    cmd(8'ha2, 8'h05, 8'h00, seed, 1'b0);
    cmd(8'h3a, 8'h05, 8'h05, 32'h0, 1'b0);
    lock <= 64'h0;
    cmd(8'ha2, 8'h04, 8'h00, seed, 1'b1);
    cmd(8'h3a, 8'h04, 8'h04, 32'h0, 1'b1);
    cmd(8'h30, 8'h04, 8'h00, 32'h0, 1'b0);
    cmd(8'h3a, 8'h04, 8'h05, 32'h0, 1'b0);
    $display("test lock and frame faults done");
    start_pg <= 8'h10;
    lvl <= 1'b1;
    cmd(8'h3a, 8'h00, 8'h0f, 32'h0, 1'b0);
    cmd(8'h3a, 8'h0e, 8'h10, 32'h0, 1'b0);
    cmd(8'ha2, 8'h10, 8'h00, seed, 1'b0);
    cmd(8'ha2, 8'h0f, 8'h00, seed, 1'b0);
    lvl <= 1'b0;
    cmd(8'h3a, 8'h0e, 8'h12, 32'h0, 1'b0);
    cmd(8'ha2, 8'h11, 8'h00, seed, 1'b0);
    auth <= 1'b1;
    lvl <= 1'b1;
    cmd(8'ha2, 8'h10, 8'h00, seed, 1'b0);
    cmd(8'h3a, 8'h0f, 8'h11, 32'h0, 1'b0);
    $display("test protection done");
    cnt_val <= seed[23:0];
    cmd(8'h39, 8'h02, 8'h00, 32'h0, 1'b0);
    cmd(8'h39, 8'h01, 8'h00, 32'h0, 1'b0);
    cmd(8'h39, 8'h02, 8'h00, 32'h0, 1'b1);
    $display("test counter done");
    repeat (30)
    begin
      auth <= seed[20];
      lvl <= seed[21];
      start_pg <= {2'b0, seed[29:24]};
      cnt_val <= seed[31:8];
      lock <= {seed, seed} & {32'h0, seed};
      cmd(OPS[seed[1:0]], {2'b0, seed[13:8]}, {2'b0, seed[13:8]} + {6'h0, seed[17:16]}, seed, seed[30] & seed[9]);
    end
    idle();
    $display("test random mix done");
    check("write pulses", 10'(n_done), 10'(n_wr));
    check("timeouts", 10'(n_to), 10'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
